// ==== sp4_defines.svh ====
// constants for the four-mode serial port: offsets, fields, resets, timing
//
// Operation
// - transmit and receive paths run independently; in shift mode they share one shifter and run half duplex
// - new character is dropped while previous one is unread
// - data write loads transmit, read returns receive
// - control bits 7:6 select one of four modes
// - fixed-rate mode runs at core/32 or core/16
// - rate-double bit picks core/16, else core/32
// - 9-bit multiproc: ninth bit 0 suppresses flag
// - 8-bit multiproc: flag needs valid stop bit
// - 9-bit modes send control bit 3 ninth
// - control bit 2 latches ninth or stop bit
// - transmit flag at eighth bit end/stop start
// - receive flag at eighth bit end/mid stop
// - shift mode: data on rx line, clock on tx
// - shift mode transmits on any data write
// - shift mode receives while enabled and flag clear
// - 8-bit frame: start, eight data, stop, ten bits
// - variable rate from one of two timer overflows
// - sixteen overflow pulses advance one serial bit
// - 8-bit mode loads stop bit into ninth position
// - falling receive edge starts, start bit validated
// - final shift stores data only if conditions met
// - 9-bit frame: start, eight data, ninth, stop
// - mode 3 equals mode 2 with timer rate
`ifndef SP4_DEFINES_SVH
`define SP4_DEFINES_SVH

`define SP4_ADDR_CONTROL 8'h98
`define SP4_ADDR_BUFFER 8'h99
`define SP4_CONTROL_RESET 8'h00
`define SP4_BUFFER_RESET 8'h00

`define SP4_BIT_MODE_HIGH 7
`define SP4_BIT_MODE_LOW 6
`define SP4_BIT_MULTIPROC 5
`define SP4_BIT_RX_ENABLE 4
`define SP4_BIT_TX_NINTH 3
`define SP4_BIT_RX_NINTH 2
`define SP4_BIT_TX_DONE 1
`define SP4_BIT_RX_DONE 0

`define SP4_TICKS_PER_BIT 5'h10
`define SP4_SAMPLE_TICK 4'h7
`define SP4_LAST_TICK 4'hF
`define SP4_SHIFT_BITS 4'h8
`define SP4_FRAME_BITS_8 4'hA
`define SP4_FRAME_BITS_9 4'hB
`define SP4_FIFO_DEPTH 16
`define SP4_DATA_WIDTH 8

`endif

// ==== sp4_pkg.sv ====
// types shared by the four-mode serial port
package sp4_pkg;

    typedef enum logic [1:0] {
        SP4_MODE_SHIFT,
        SP4_MODE_UART8,
        SP4_MODE_UART9_FIXED,
        SP4_MODE_UART9_VAR
    } sp4_mode_t;

    typedef enum logic [1:0] {
        SP4_RX_IDLE,
        SP4_RX_START,
        SP4_RX_DATA,
        SP4_RX_STOP
    } sp4_rx_state_t;

endpackage

// ==== sp4_remote_model.sv ====
// remote serial transceiver facing the port's line pins
module sp4_remote_model (
    input wire logic clock_in,
    input wire logic txd_in,
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // line rests at its pull-up level between frames; frame bit 0 goes first
    initial line_out = 1'b1;
    task automatic send(input logic [10:0] f, input int n, input int cyc);
        for (int i = 0; i < n; i++) begin
            @(negedge clock_in);
            line_out = f[i];
            repeat (cyc - 1) @(negedge clock_in);
        end
        @(negedge clock_in);
        line_out = 1'b1;
    endtask
    // returns at mid stop bit so back-to-back frames stay aligned
    task automatic grab(output logic [10:0] f, input int n, input int cyc);
        int k;
        f = 'x;
        k = 0;
        while (txd_in !== 1'b0 && k < 4000) begin
            @(negedge clock_in);
            k++;
        end
        if (k < 4000) begin
            f = '0;
            repeat (cyc / 2) @(negedge clock_in);
            for (int i = 0; i < n; i++) begin
                if (i > 0) repeat (cyc) @(negedge clock_in);
                f[i] = txd_in;
            end
        end
    endtask
endmodule

// ==== sp4_uart.sv ====
// four-mode serial port with its transmit fifo
`include "sp4_defines.svh"

// ----------------------------------------------------------------
// transmit fifo
// ----------------------------------------------------------------
module sp4_fifo #(
    parameter int WIDTH = `SP4_DATA_WIDTH,
    parameter int DEPTH = `SP4_FIFO_DEPTH
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } sp4_fifo_state_t;

    sp4_fifo_state_t s_q;
    sp4_fifo_state_t s_d;
    logic push;
    logic pop;

    always_comb begin
        s_d = s_q;
        push = in_valid_in && (s_q.count != (AW+1)'(DEPTH));
        pop = out_ready_in && (s_q.count != '0);
        if (push) begin
            s_d.mem[s_q.wr] = in_data_in;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        if (push && !pop) begin
            s_d.count = s_q.count + 1'b1;
        end else if (pop && !push) begin
            s_d.count = s_q.count - 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready_out = (s_q.count != (AW+1)'(DEPTH));
    assign out_valid_out = (s_q.count != '0);
    assign out_data_out = s_q.mem[s_q.rd];
endmodule

// ----------------------------------------------------------------
// serial port top
// ----------------------------------------------------------------
module sp4_uart (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    output logic tx_ready_out,
    input wire logic rate_double_bit_in,
    input wire logic timer1_ovf_in,
    input wire logic timer2_ovf_in,
    input wire logic rx_use_timer2_in,
    input wire logic tx_use_timer2_in,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe_out,
    output logic txd_out
);
    typedef struct packed {
        logic [2:0] rxd_sync;
        logic rxd_f;
        logic rxd_prev;
        logic [7:0] serial_control;
        logic [7:0] rx_hold;
        logic [7:0] rdata;
        logic fixed_div;
        logic [10:0] tx_sh;
        logic [3:0] tx_left;
        logic [3:0] tx_sub;
        logic tx_busy;
        logic txd;
        logic m0_busy;
        logic m0_is_tx;
        logic m0_phase;
        logic [3:0] m0_cnt;
        logic [7:0] m0_sh;
        logic rxd_drv;
        logic rxd_oe;
        sp4_pkg::sp4_rx_state_t rx_st;
        logic [3:0] rx_sub;
        logic [3:0] rx_cnt;
        logic [8:0] rx_sh;
        logic tx_rdy;
    } sp4_state_t;

    sp4_state_t s_q;
    sp4_state_t s_d;
    logic [1:0] rst_sync_q;
    logic rst_b;
    logic fifo_push;
    logic fifo_in_ready;
    logic fifo_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;
    sp4_pkg::sp4_mode_t mode;
    logic nine_bit;
    logic tx_tick;
    logic rx_tick;
    logic sample;
    logic mp_ok;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // each direction picks its own overflow source, so rates may differ
    function automatic logic sp4_pick_tick(input logic use_t2, input logic ovf1,
                                           input logic ovf2);
        return use_t2 ? ovf2 : ovf1;
    endfunction

    function automatic logic sp4_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_q[1];

    // writes are dropped here when full; software watches tx_ready_out first
    sp4_fifo #(
        .WIDTH(`SP4_DATA_WIDTH),
        .DEPTH(`SP4_FIFO_DEPTH)
    ) u_tx_fifo (
        .clock_in(clock_in),
        .rst_b_in(rst_b),
        .in_valid_in(fifo_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(sfr_wdata_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_data)
    );

    assign fifo_push = sfr_wr_in && sp4_hit(sfr_addr_in, `SP4_ADDR_BUFFER);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        fifo_pop = 1'b0;
        sample = 1'b0;
        mp_ok = 1'b0;
        mode = sp4_pkg::sp4_mode_t'({s_q.serial_control[`SP4_BIT_MODE_HIGH],
                                     s_q.serial_control[`SP4_BIT_MODE_LOW]});
        nine_bit = s_q.serial_control[`SP4_BIT_MODE_HIGH];

        // pin filter: a level counts once the last two stages agree
        s_d.rxd_sync = {s_q.rxd_sync[1:0], rxd_in};
        if (s_q.rxd_sync[1] == s_q.rxd_sync[2]) begin
            s_d.rxd_f = s_q.rxd_sync[2];
        end
        s_d.rxd_prev = s_q.rxd_f;

        // sixteen sample ticks per bit in every uart mode
        s_d.fixed_div = ~s_q.fixed_div;
        if (mode == sp4_pkg::SP4_MODE_UART9_FIXED) begin
            tx_tick = rate_double_bit_in | s_q.fixed_div;
            rx_tick = tx_tick;
        end else begin
            tx_tick = sp4_pick_tick(tx_use_timer2_in, timer1_ovf_in,
                                    timer2_ovf_in);
            rx_tick = sp4_pick_tick(rx_use_timer2_in, timer1_ovf_in,
                                    timer2_ovf_in);
        end

        // software access; hardware flag sets below win over clears
        if (sfr_wr_in && sp4_hit(sfr_addr_in, `SP4_ADDR_CONTROL)) begin
            s_d.serial_control = sfr_wdata_in;
        end
        if (sfr_rd_in) begin
            case (sfr_addr_in)
                `SP4_ADDR_CONTROL: s_d.rdata = s_q.serial_control;
                `SP4_ADDR_BUFFER: s_d.rdata = s_q.rx_hold;
                default: s_d.rdata = 8'h00;
            endcase
        end
        s_d.tx_rdy = fifo_in_ready;

        if (mode == sp4_pkg::SP4_MODE_SHIFT) begin
            // ------------------------------------------------------------
            // shift mode: half duplex, clock at core/2 on the tx line
            // ------------------------------------------------------------
            s_d.tx_busy = 1'b0;
            s_d.rx_st = sp4_pkg::SP4_RX_IDLE;
            if (!s_q.m0_busy) begin
                s_d.txd = 1'b1;
                s_d.rxd_oe = 1'b0;
                if (fifo_valid) begin
                    fifo_pop = 1'b1;
                    s_d.m0_busy = 1'b1;
                    s_d.m0_is_tx = 1'b1;
                    s_d.m0_sh = fifo_data;
                    s_d.m0_cnt = 4'h0;
                    s_d.m0_phase = 1'b0;
                end else if (s_q.serial_control[`SP4_BIT_RX_ENABLE]
                             && !s_q.serial_control[`SP4_BIT_RX_DONE]) begin
                    s_d.m0_busy = 1'b1;
                    s_d.m0_is_tx = 1'b0;
                    s_d.m0_cnt = 4'h0;
                    s_d.m0_phase = 1'b0;
                end
            end else begin
                s_d.m0_phase = ~s_q.m0_phase;
                s_d.txd = s_q.m0_phase ? 1'b1 : 1'b0;
                s_d.rxd_oe = s_q.m0_is_tx;
                s_d.rxd_drv = s_q.m0_sh[0];
                if (s_q.m0_phase) begin
                    // the pin filter delays captured data by a few core cycles
                    s_d.m0_sh = {s_q.rxd_f, s_q.m0_sh[7:1]};
                    s_d.m0_cnt = s_q.m0_cnt + 4'h1;
                    if (s_q.m0_cnt == `SP4_SHIFT_BITS - 4'h1) begin
                        s_d.m0_busy = 1'b0;
                        s_d.txd = 1'b1;
                        if (s_q.m0_is_tx) begin
                            s_d.serial_control[`SP4_BIT_TX_DONE] = 1'b1;
                        end else begin
                            s_d.rx_hold = {s_q.rxd_f, s_q.m0_sh[7:1]};
                            s_d.serial_control[`SP4_BIT_RX_DONE] = 1'b1;
                        end
                    end
                end
            end
        end else begin
            s_d.m0_busy = 1'b0;
            s_d.rxd_oe = 1'b0;
            // ------------------------------------------------------------
            // uart transmitter
            // ------------------------------------------------------------
            if (!s_q.tx_busy) begin
                s_d.txd = 1'b1;
                if (fifo_valid && tx_tick) begin
                    fifo_pop = 1'b1;
                    s_d.tx_busy = 1'b1;
                    s_d.tx_sub = 4'h0;
                    if (nine_bit) begin
                        s_d.tx_sh = {1'b1, s_q.serial_control[`SP4_BIT_TX_NINTH],
                                     fifo_data, 1'b0};
                        s_d.tx_left = `SP4_FRAME_BITS_9;
                    end else begin
                        s_d.tx_sh = {2'h3, fifo_data, 1'b0};
                        s_d.tx_left = `SP4_FRAME_BITS_8;
                    end
                    s_d.txd = 1'b0;
                end
            end else if (tx_tick) begin
                s_d.tx_sub = s_q.tx_sub + 4'h1;
                if (s_q.tx_sub == `SP4_LAST_TICK) begin
                    s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
                    s_d.tx_left = s_q.tx_left - 4'h1;
                    s_d.txd = s_q.tx_sh[1];
                    if (s_q.tx_left == 4'h2) begin
                        s_d.serial_control[`SP4_BIT_TX_DONE] = 1'b1;
                    end
                    if (s_q.tx_left == 4'h1) begin
                        s_d.tx_busy = 1'b0;
                        s_d.txd = 1'b1;
                    end
                end
            end
            // ------------------------------------------------------------
            // uart receiver, runs beside the transmitter
            // ------------------------------------------------------------
            case (s_q.rx_st)
                sp4_pkg::SP4_RX_IDLE: begin
                    if (s_q.serial_control[`SP4_BIT_RX_ENABLE] && s_q.rxd_prev
                        && !s_q.rxd_f) begin
                        s_d.rx_st = sp4_pkg::SP4_RX_START;
                        s_d.rx_sub = 4'h0;
                        s_d.rx_cnt = 4'h0;
                    end
                end
                default: begin
                    if (rx_tick) begin
                        s_d.rx_sub = s_q.rx_sub + 4'h1;
                        sample = (s_q.rx_sub == `SP4_SAMPLE_TICK);
                    end
                end
            endcase
            if (sample) begin
                case (s_q.rx_st)
                    sp4_pkg::SP4_RX_START: begin
                        // a glitch that has gone high by mid-bit is dropped
                        s_d.rx_st = s_q.rxd_f ? sp4_pkg::SP4_RX_IDLE
                                              : sp4_pkg::SP4_RX_DATA;
                    end
                    sp4_pkg::SP4_RX_DATA: begin
                        s_d.rx_sh = {s_q.rxd_f, s_q.rx_sh[8:1]};
                        s_d.rx_cnt = s_q.rx_cnt + 4'h1;
                        if (s_q.rx_cnt == (nine_bit ? 4'h8 : 4'h7)) begin
                            s_d.rx_st = sp4_pkg::SP4_RX_STOP;
                        end
                    end
                    sp4_pkg::SP4_RX_STOP: begin
                        s_d.rx_st = sp4_pkg::SP4_RX_IDLE;
                        if (nine_bit) begin
                            mp_ok = !s_q.serial_control[`SP4_BIT_MULTIPROC]
                                    || s_q.rx_sh[8];
                        end else begin
                            mp_ok = !s_q.serial_control[`SP4_BIT_MULTIPROC]
                                    || s_q.rxd_f;
                        end
                        // the flag is set halfway through the stop bit
                        if (!s_q.serial_control[`SP4_BIT_RX_DONE] && mp_ok
                            && s_q.rxd_f) begin
                            s_d.rx_hold = nine_bit ? s_q.rx_sh[7:0]
                                                   : s_q.rx_sh[8:1];
                            s_d.serial_control[`SP4_BIT_RX_NINTH] =
                                nine_bit ? s_q.rx_sh[8] : s_q.rxd_f;
                            s_d.serial_control[`SP4_BIT_RX_DONE] = 1'b1;
                        end
                    end
                    default: s_d.rx_st = sp4_pkg::SP4_RX_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.rxd_sync <= 3'h7;
            s_q.rxd_f <= 1'b1;
            s_q.rxd_prev <= 1'b1;
            s_q.txd <= 1'b1;
            s_q.serial_control <= `SP4_CONTROL_RESET;
            s_q.rx_hold <= `SP4_BUFFER_RESET;
            s_q.rx_st <= sp4_pkg::SP4_RX_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata_out = s_q.rdata;
    assign tx_ready_out = s_q.tx_rdy;
    assign rxd_out = s_q.rxd_drv;
    assign rxd_oe_out = s_q.rxd_oe;
    assign txd_out = s_q.txd;
endmodule

// ==== sp4_uart_properties.sv ====
// concurrent checks on the four-mode serial port top, bound to sp4_uart
module sp4_uart_chk (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic rxd_out,
    input wire logic rxd_oe_out,
    input wire logic txd_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // --------------------------------
    // helper state
    // --------------------------------
    // every written control bit is mirrored; readback compares bits 7:3 only, flags belong to hardware
    logic [7:0] ctrl_q;
    logic [11:0] low_q;
    wire uart = ctrl_q[7:6] != 2'h0;
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_q <= 8'h00;
            low_q <= 12'h000;
        end else begin
            if (sfr_wr_in && sfr_addr_in == 8'h98) ctrl_q <= sfr_wdata_in;
            low_q <= txd_out ? 12'h000 : low_q + 12'h001;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    // --------------------------------
    // properties
    // --------------------------------
    property p_oe_mode0;
        rxd_oe_out |-> !uart;
    endproperty
    a_oe_mode0: assert property (p_oe_mode0) else $error("rx line driven in uart mode");
    // any steady tick period gives runs that are whole multiples of sixteen
    property p_bit_len;
        $rose(txd_out) && uart |-> low_q[3:0] == 4'h0;
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("tx low run not whole bits");
    property p_shift_clk;
        !uart && $fell(txd_out) |=> txd_out;
    endproperty
    a_shift_clk: assert property (p_shift_clk) else $error("shift clock low too long");
    property p_oe_start;
        $rose(rxd_oe_out) |-> !txd_out;
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("shift out began on clock high");
    property p_hold_data;
        rxd_oe_out && txd_out |-> $stable(rxd_out);
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("shift data moved on clock high");
    property p_rd_hold;
        !$past(sfr_rd_in) |-> $stable(sfr_rdata_out);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    property p_unmapped;
        sfr_rd_in && sfr_addr_in != 8'h98 && sfr_addr_in != 8'h99 |=> sfr_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctrl_rb;
        sfr_rd_in && sfr_addr_in == 8'h98 |=> (sfr_rdata_out & 8'hF8) == ($past(ctrl_q) & 8'hF8);
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
    c_shift: cover property ($rose(rxd_oe_out));
    c_frame: cover property ($rose(txd_out) && uart);
    c_unmapped: cover property (sfr_rd_in && sfr_addr_in == 8'h9A);
endmodule

bind sp4_uart sp4_uart_chk u_chk (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .rxd_out(rxd_out),
    .rxd_oe_out(rxd_oe_out), .txd_out(txd_out));

// ==== sp4_uart_tb.sv ====
// self-checking bench for the four-mode serial port
module sp4_uart_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b, wr, rd, dbl, rxu2, txu2, rxd_o, oe, txd, tx_rdy, line, t1, t2;
    logic [7:0] addr, wdata, rdata, v;
    logic [1:0] tc;
    logic [10:0] f;
    int failures, compares, n;
    wire rxd = oe ? rxd_o : line;
    assign t1 = !tc[0];
    assign t2 = tc == 2'h0;
    sp4_uart dut (.clock_in(clk), .rst_b_in(rst_b), .sfr_addr_in(addr), .sfr_wr_in(wr),
        .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .tx_ready_out(tx_rdy),
        .rate_double_bit_in(dbl), .timer1_ovf_in(t1), .timer2_ovf_in(t2),
        .rx_use_timer2_in(rxu2), .tx_use_timer2_in(txu2), .rxd_in(rxd), .rxd_out(rxd_o),
        .rxd_oe_out(oe), .txd_out(txd));
    sp4_remote_model far (.clock_in(clk), .txd_in(txd), .line_out(line));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // overflow pulses: first timer every 2 cycles, second every 4
    always @(negedge clk) tc <= rst_b ? tc + 2'h1 : 2'h0;
    // --------------------------------
    // tasks
    // --------------------------------
    task automatic test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        test_done();
    end
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        rst_b = 1'b0; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
        dbl = 1'b1; rxu2 = 1'b0; txu2 = 1'b1; failures = 0; compares = 0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        rd_reg(8'h98, v); chk("control reset", v, 8'h00);
        rd_reg(8'h99, v); chk("buffer reset", v, 8'h00);
        rd_reg(8'h9A, v); chk("unmapped", v, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr_reg(8'h98, {m[1:0], 6'h28});
            rd_reg(8'h98, v); chk("mode bits", v, {m[1:0], 6'h28});
        end
        // fast fixed rate, both directions at once
        wr_reg(8'h98, 8'h90);
        fork
            wr_reg(8'h99, 8'hA5);
            far.grab(f, 11, 16);
            far.send({2'b11, 8'h3C, 1'b0}, 11, 16);
        join
        chk("tx frame mode2", f, {2'b10, 8'hA5, 1'b0});
        rd_reg(8'h98, v); chk("flags mode2", v, 8'h97);
        rd_reg(8'h99, v); chk("rx data mode2", v, 8'h3C);
        far.send({2'b11, 8'h55, 1'b0}, 11, 16);
        rd_reg(8'h99, v); chk("unread kept", v, 8'h3C);
        wr_reg(8'h98, 8'hB0);
        far.send({2'b10, 8'h11, 1'b0}, 11, 16);
        rd_reg(8'h98, v); chk("ninth zero", v, 8'hB0);
        far.send({2'b11, 8'h22, 1'b0}, 11, 16);
        rd_reg(8'h98, v); chk("ninth one", v, 8'hB5);
        rd_reg(8'h99, v); chk("rx data addr", v, 8'h22);
        wr_reg(8'h98, 8'hA0);
        far.send({2'b11, 8'h33, 1'b0}, 11, 16);
        rd_reg(8'h98, v); chk("rx disabled", v, 8'hA0);
        wr_reg(8'h98, 8'h90);
        far.send(11'h000, 1, 5);
        repeat (40) @(negedge clk);
        rd_reg(8'h98, v); chk("false start", v, 8'h90);
        // timer rate: tx on second timer, rx on first
        wr_reg(8'h98, 8'h70);
        fork
            wr_reg(8'h99, 8'h5A);
            far.grab(f, 10, 64);
            far.send({1'b1, 8'hC3, 1'b0}, 10, 32);
        join
        chk("tx frame mode1", f, {1'b1, 8'h5A, 1'b0});
        rd_reg(8'h98, v); chk("flags mode1", v, 8'h77);
        rd_reg(8'h99, v); chk("rx data mode1", v, 8'hC3);
        wr_reg(8'h98, 8'h70);
        far.send({1'b0, 8'h0F, 1'b0}, 10, 32);
        rd_reg(8'h98, v); chk("bad stop", v, 8'h70);
        // nine-bit timer rate: tx on first timer, rx on second
        rxu2 = 1'b1;
        txu2 = 1'b0;
        wr_reg(8'h98, 8'hD8);
        fork
            wr_reg(8'h99, 8'h81);
            far.grab(f, 11, 32);
            far.send({2'h3, 8'h6E, 1'b0}, 11, 64);
        join
        chk("tx frame mode3", f, {2'h3, 8'h81, 1'b0});
        rd_reg(8'h98, v); chk("flags mode3", v, 8'hDF);
        rd_reg(8'h99, v); chk("rx data mode3", v, 8'h6E);
        // shift register mode
        wr_reg(8'h98, 8'h00);
        wr_reg(8'h99, 8'h96);
        n = 0;
        for (int k = 0; k < 200 && n < 8; k++) begin
            @(negedge clk);
            if (oe === 1'b1 && txd === 1'b0) begin
                v[n] = rxd_o;
                n++;
            end
        end
        chk("shift out", v, 8'h96);
        chk("shift bits", n[10:0], 11'h008);
        rd_reg(8'h98, v); chk("shift tx flag", v, 8'h02);
        wr_reg(8'h98, 8'h10);
        repeat (60) @(negedge clk);
        rd_reg(8'h98, v); chk("shift rx flag", v[0], 1'b1);
        rd_reg(8'h99, v); chk("shift rx data", v, 8'hFF);
        // fill the transmit queue until refused, drain at the slow fixed rate
        dbl = 1'b0;
        wr_reg(8'h98, 8'h88);
        n = 0;
        fork
            while (tx_rdy === 1'b1 && n < 40) begin
                wr_reg(8'h99, n[7:0]);
                n++;
                @(negedge clk);
            end
            for (int i = 0; i < 17; i++) begin
                far.grab(f, 11, 32);
                chk("queued frame", f, {2'b11, i[7:0], 1'b0});
            end
        join
        chk("accepted writes", n[10:0], 11'h011);
        chk("queue empty", tx_rdy, 1'b1);
        test_done();
    end
endmodule
